//--- hw/rim_defs.svh
// frame layout constants for the remote io frame mapper
`ifndef RIM_DEFS_SVH
`define RIM_DEFS_SVH
`define RIM_FRAME_BYTES    32
`define RIM_REFRESH_CODE   8'h20
`define RIM_BYTE_CODE      0
`define RIM_BYTE_WDT       1
`define RIM_BYTE_CTRL      2
`define RIM_BYTE_CONN      4
`define RIM_BYTE_SLOT0     6
`define RIM_BYTE_REGADDR   22
`define RIM_BYTE_CMDWORD   24
`define RIM_BYTE_DATA      26
`define RIM_BYTE_RSVD      31
`define RIM_BIT_KICK       6
`define RIM_BIT_STATUS     7
`define RIM_DONE_LATENCY   4
`endif

//--- hw/rim_pkg.sv
// types shared by the remote io frame mapper
package rim_pkg;
  typedef logic [7:0] rim_byte_t;
  // per-axis command bits
  typedef struct packed {
    logic [5:0] op_select;
    logic       start;
    logic       run_positive;
    logic       run_negative;
    logic       home;
    logic       stop;
    logic       excite_enable;
  } rim_axis_cmd_s;
  // per-axis status bits
  typedef struct packed {
    logic [5:0] op_select_echo;
    logic       warning_flag;
    logic       alarm_flag;
    logic       start_echo;
    logic       lost_step_flag;
    logic       motion_flag;
    logic       homed_flag;
    logic       ready;
    logic       inside_zone_flag;
  } rim_axis_stat_s;
  // decoded motion action after priority
  typedef struct packed {
    logic excite;
    logic halt;
    logic run_pos;
    logic run_neg;
    logic home_go;
    logic start_go;
  } rim_action_s;
  typedef enum logic [1:0] {RIM_IDLE, RIM_BUSY, RIM_DONE} rim_state_e;
endpackage : rim_pkg

//--- hw/rim_frame_mapper.sv
// remote io frame mapper: unpacks command frames, builds response frames
`timescale 1ns/1ps
`default_nettype none
`include "rim_defs.svh"
module rim_frame_mapper
  import rim_pkg::*;
#(
  parameter int AXES16     = 16,
  parameter int DONE_LAT   = `RIM_DONE_LATENCY
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                mode_8bit,
  input  wire logic                rx_valid,
  input  wire logic [255:0]        rx_frame,
  input  wire logic [7:0]          conn_status,
  input  wire logic [15:0]         frame_status,
  input  wire rim_axis_stat_s [15:0] axis_stat,
  input  wire logic                cmd_result_error,
  input  wire logic [31:0]         cmd_result_data,
  output var  rim_axis_cmd_s [15:0] axis_cmd,
  output var  rim_action_s [15:0]  axis_action,
  output logic [15:0]              frame_control,
  output logic [7:0]               reg_address,
  output logic [13:0]              cmd_code,
  output logic [31:0]              cmd_data,
  output logic                     cmd_start,
  output logic                     tx_valid,
  output logic [255:0]             tx_frame
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg, rst_n_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // frame byte view
  // ---------------------------------------------------------------
  rim_byte_t rx_b [0:31];
  for (genvar i = 0; i < 32; i++) begin : g_rxb
    assign rx_b[i] = rx_frame[8*i +: 8];
  end
  wire frame_ok = rx_valid && (rx_b[`RIM_BYTE_CODE] == `RIM_REFRESH_CODE);
  wire [15:0] ctrl_w = {rx_b[`RIM_BYTE_CTRL+1], rx_b[`RIM_BYTE_CTRL]};
  wire [15:0] cmdw   = {rx_b[`RIM_BYTE_CMDWORD+1], rx_b[`RIM_BYTE_CMDWORD]};
  wire [31:0] data_w = {rx_b[`RIM_BYTE_DATA+3], rx_b[`RIM_BYTE_DATA+2],
                        rx_b[`RIM_BYTE_DATA+1], rx_b[`RIM_BYTE_DATA]};
  wire        kick   = cmdw[8+`RIM_BIT_KICK];

  // ---------------------------------------------------------------
  // per-axis input decode and priority
  // ---------------------------------------------------------------
  rim_axis_cmd_s [15:0] cmd_next;
  rim_action_s   [15:0] act_next;
  for (genvar a = 0; a < 16; a++) begin : g_axis
    // 16-bit: axes 0..7 at 6+2n; 8-bit: axes 0..15 at 6+n
    wire rim_byte_t lo = rx_b[`RIM_BYTE_SLOT0 + 2*(a%8)];
    wire rim_byte_t hi = rx_b[`RIM_BYTE_SLOT0 + 2*(a%8) + 1];
    wire rim_byte_t by = rx_b[`RIM_BYTE_SLOT0 + a];
    wire rim_byte_t sel = mode_8bit ? by : hi;
    wire live = mode_8bit || (a < 8);
    assign cmd_next[a].op_select     = (live && !mode_8bit) ? lo[5:0] : 6'h00;
    assign cmd_next[a].start         = live & sel[0];
    assign cmd_next[a].run_positive  = live & sel[1];
    assign cmd_next[a].run_negative  = live & sel[2];
    assign cmd_next[a].home          = live & sel[3];
    assign cmd_next[a].stop          = live & sel[4];
    assign cmd_next[a].excite_enable = live & sel[5];
    // priority: no excitation or stop masks all motion
    wire c_en = cmd_next[a].excite_enable;
    wire c_go = c_en && !cmd_next[a].stop;
    wire both = cmd_next[a].run_positive && cmd_next[a].run_negative;
    wire runs = cmd_next[a].run_positive || cmd_next[a].run_negative;
    assign act_next[a].excite   = c_en;
    assign act_next[a].halt     = !c_go || both;
    assign act_next[a].run_pos  = c_go && cmd_next[a].run_positive && !both;
    assign act_next[a].run_neg  = c_go && cmd_next[a].run_negative && !both;
    assign act_next[a].home_go  = c_go && !runs && cmd_next[a].home &&
                                  !axis_cmd[a].home;
    assign act_next[a].start_go = c_go && !runs && !cmd_next[a].home &&
                                  cmd_next[a].start && !axis_cmd[a].start;
  end

  // ---------------------------------------------------------------
  // register command handshake
  // ---------------------------------------------------------------
  rim_state_e st_reg, st_next;
  logic       kick_reg;
  logic [7:0] lat_reg;
  logic       ack_reg, err_reg;
  logic [31:0] rdata_reg;
  // a command starts only on a kick edge between accepted frames
  wire kick_rise = frame_ok && kick && !kick_reg;
  // a frame that kicks a new command must not report the old one as done
  wire ack_shown = ack_reg && !kick_rise;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      RIM_IDLE: if (kick_rise) st_next = RIM_BUSY;
      RIM_BUSY: if (lat_reg == 8'(DONE_LAT - 1)) st_next = RIM_DONE;
      RIM_DONE: if (kick_rise) st_next = RIM_BUSY;
      default:  st_next = RIM_IDLE;
    endcase
  end

  // state and handshake registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg    <= RIM_IDLE;
      kick_reg  <= 1'b0;
      lat_reg   <= 8'h00;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      st_reg   <= st_next;
      if (frame_ok) kick_reg <= kick;
      lat_reg  <= (st_reg == RIM_BUSY) ? lat_reg + 8'h01 : 8'h00;
      // completion wins over a kick that lands in the same cycle
      if (st_reg == RIM_BUSY && st_next == RIM_DONE) begin
        ack_reg   <= 1'b1;
        err_reg   <= cmd_result_error;
        rdata_reg <= cmd_result_data;
      end else if (kick_rise) ack_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // response frame assembly
  // ---------------------------------------------------------------
  rim_byte_t tx_b [0:31];
  assign tx_b[`RIM_BYTE_CODE]   = `RIM_REFRESH_CODE;
  assign tx_b[`RIM_BYTE_WDT]    = rx_b[`RIM_BYTE_WDT];
  assign tx_b[`RIM_BYTE_CTRL]   = frame_status[7:0];
  assign tx_b[`RIM_BYTE_CTRL+1] = frame_status[15:8];
  assign tx_b[`RIM_BYTE_CONN]   = conn_status;
  assign tx_b[`RIM_BYTE_CONN+1] = 8'h00;
  for (genvar s = 0; s < 16; s++) begin : g_out
    // 8-bit mode reports axis s, 16-bit mode axis s/2 in two bytes
    wire rim_axis_stat_s q = axis_stat[s];
    wire rim_axis_stat_s p = axis_stat[s/2];
    wire rim_byte_t w_lo = {p.alarm_flag, p.warning_flag, p.op_select_echo};
    wire rim_byte_t w_hi = {p.inside_zone_flag, 1'b0, p.ready, 1'b0,
                            p.homed_flag, p.motion_flag, p.lost_step_flag,
                            p.start_echo};
    wire rim_byte_t w_8  = {q.inside_zone_flag, 1'b0, q.ready, q.alarm_flag,
                            q.homed_flag, q.motion_flag, q.lost_step_flag,
                            q.start_echo};
    // byte 6+s: 8-bit mode slot s, or 16-bit axis s/2 low/high half
    wire rim_byte_t w_16 = (s % 2 == 0) ? w_lo : w_hi;
    assign tx_b[`RIM_BYTE_SLOT0 + s] = mode_8bit ? w_8 : w_16;
  end
  assign tx_b[`RIM_BYTE_REGADDR]   = rx_b[`RIM_BYTE_REGADDR];
  assign tx_b[`RIM_BYTE_REGADDR+1] = rx_b[`RIM_BYTE_REGADDR+1];
  assign tx_b[`RIM_BYTE_CMDWORD]   = cmdw[7:0];
  assign tx_b[`RIM_BYTE_CMDWORD+1] = {err_reg, ack_shown, cmdw[13:8]};
  for (genvar d = 0; d < 4; d++) begin : g_dat
    assign tx_b[`RIM_BYTE_DATA + d] = rdata_reg[8*d +: 8];
  end
  assign tx_b[30]             = 8'h00;
  assign tx_b[`RIM_BYTE_RSVD] = 8'h00;
  logic [255:0] tx_next;
  for (genvar t = 0; t < 32; t++) begin : g_txp
    assign tx_next[8*t +: 8] = tx_b[t];
  end

  // ---------------------------------------------------------------
  // output registers, refreshed on each accepted frame; cmd_start and tx_valid every cycle; command code and data only on a kick edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      axis_cmd      <= '0;
      axis_action   <= '0;
      frame_control <= 16'h0000;
      reg_address   <= 8'h00;
      cmd_code      <= 14'h0000;
      cmd_data      <= 32'h0000_0000;
      cmd_start     <= 1'b0;
      tx_valid      <= 1'b0;
      tx_frame      <= '0;
    end else begin
      cmd_start <= kick_rise;
      tx_valid  <= frame_ok;
      if (frame_ok) begin
        axis_cmd      <= cmd_next;
        axis_action   <= act_next;
        frame_control <= ctrl_w;
        reg_address   <= rx_b[`RIM_BYTE_REGADDR];
        tx_frame      <= tx_next;
      end
      if (kick_rise) begin
        cmd_code <= cmdw[13:0];
        cmd_data <= data_w;
      end
    end
  end
endmodule : rim_frame_mapper
`default_nettype wire

//--- verification/rim_frame_mapper_asserts.sv
// port assertions for the remote io frame mapper
`timescale 1ns/1ps
`default_nettype none
module rim_frame_mapper_asserts
  import rim_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 mode_8bit,
  input wire logic                 rx_valid,
  input wire logic [255:0]         rx_frame,
  input wire rim_axis_cmd_s [15:0] axis_cmd,
  input wire rim_action_s [15:0]   axis_action,
  input wire logic [31:0]          cmd_data,
  input wire logic                 cmd_start,
  input wire logic                 tx_valid,
  input wire logic [255:0]         tx_frame
);
  // ----
  // acceptance and kick level of the last accepted frame
  // ----
  logic take;
  logic kick_reg;
  assign take = rx_valid && rx_frame[7:0] == 8'h20;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) kick_reg <= 1'b0;
    else if (take) kick_reg <= rx_frame[206];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  reply_after_a: assert property (take |=> tx_valid)
    else $error("no reply");
  refused_code_a: assert property (!take |=> !tx_valid)
    else $error("stray reply");
  frame_ends_a: assert property (tx_valid |->
    tx_frame[7:0] == 8'h20 && tx_frame[255:248] == 8'h00)
    else $error("bad reply framing");
  wdt_echo_a: assert property (tx_valid |->
    tx_frame[15:8] == $past(rx_frame[15:8])) else $error("no echo");
  kick_start_a: assert property (take && rx_frame[206] && !kick_reg
    |=> cmd_start) else $error("kick rise missed");
  kick_level_a: assert property (!(take && rx_frame[206] && !kick_reg)
    |=> !cmd_start) else $error("start without rise");
  data_order_a: assert property (cmd_start |->
    cmd_data == $past(rx_frame[239:208])) else $error("data order");
  input_word_a: assert property (tx_valid && !mode_8bit |->
    axis_cmd[0].op_select == $past(rx_frame[53:48]) &&
    axis_cmd[0].start == $past(rx_frame[56]) &&
    axis_cmd[0].excite_enable == $past(rx_frame[61])) else $error("input");
  run_conflict_a: assert property (axis_action[0].run_pos |->
    !axis_action[0].run_neg && !axis_action[0].halt) else $error("runs");
endmodule : rim_frame_mapper_asserts
bind rim_frame_mapper rim_frame_mapper_asserts rim_frame_mapper_asserts_i (
  .clk, .arst_n, .mode_8bit, .rx_valid, .rx_frame, .axis_cmd, .axis_action,
  .cmd_data, .cmd_start, .tx_valid, .tx_frame);
`default_nettype wire

//--- verification/rim_converter_model.sv
// converter model: launches command frames and keeps the kick handshake
`timescale 1ns/1ps
`default_nettype none
module rim_converter_model (
  input  wire logic         clk,
  input  wire logic         send_req,
  input  wire logic [255:0] frame_req,
  input  wire logic         kick_req,
  input  wire logic         tx_valid,
  input  wire logic [255:0] tx_frame,
  output logic              rx_valid,
  output logic [255:0]      rx_frame
);
  // ----
  // frame launch
  // ----
  logic         valid_q  = 1'b0;
  logic [255:0] frame_q  = '0;
  logic         ack_seen = 1'b0;
  logic [255:0] launch;
  // kick stays low after an acknowledge until the host drops it
  always_comb begin
    launch      = frame_req;
    launch[206] = kick_req && !ack_seen;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_frame[206]) ack_seen <= 1'b1;
    else if (!kick_req) ack_seen <= 1'b0;
    valid_q <= send_req;
    frame_q <= send_req ? launch : ~frame_q; // idle data toggles
  end
  assign rx_valid = valid_q;
  assign rx_frame = frame_q;
endmodule : rim_converter_model
`default_nettype wire

//--- verification/tb_rim_frame_mapper.sv
// self-checking testbench for the remote io frame mapper
`timescale 1ns/1ps
`default_nettype none
module tb_rim_frame_mapper import rim_pkg::*; ;
  // ----
  // signals, clock, instances and access tasks
  // ----
  logic                  clk, arst_n, mode_8bit, send_req, kick_req;
  logic                  rx_valid, tx_valid, cmd_start, cmd_err, seen_start;
  logic [255:0]          frame_req, rx_frame, tx_frame, f;
  logic [31:0]           cmd_res, cmd_data;
  logic [13:0]           cmd_code;
  logic [15:0]           frm_st, frame_control;
  logic [7:0]            conn_st, reg_address;
  rim_axis_stat_s [15:0] axis_stat;
  rim_axis_cmd_s [15:0]  axis_cmd;
  rim_action_s [15:0]    axis_action;
  int                    miscompares, samples_checked;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  rim_frame_mapper rim_frame_mapper_i (
    .clk, .arst_n, .mode_8bit, .rx_valid, .rx_frame, .conn_status(conn_st),
    .frame_status(frm_st), .axis_stat, .cmd_result_error(cmd_err),
    .cmd_result_data(cmd_res), .axis_cmd, .axis_action, .frame_control,
    .reg_address, .cmd_code, .cmd_data, .cmd_start, .tx_valid, .tx_frame);
  rim_converter_model rim_converter_model_i (
    .clk, .send_req, .frame_req, .kick_req, .tx_valid, .tx_frame, .rx_valid,
    .rx_frame);
  task automatic check(input string name, input logic [255:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // one frame through the converter; waits a bounded time for the reply
  task automatic xfer(input logic [255:0] fr, input logic want);
    int n;
    @(posedge clk);
    frame_req <= fr;
    send_req <= 1'b1;
    @(posedge clk);
    send_req <= 1'b0;
    seen_start = 1'b0;
    for (n = 0; n < 6 && tx_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      seen_start = cmd_start;
    end
    check("reply", tx_valid, want);
    if (want && n == 6) summarize();
  endtask : xfer
  function automatic logic [5:0] rev6(input logic [5:0] v);
    for (int k = 0; k < 6; k++) rev6[k] = v[5-k];
  endfunction : rev6
  // reply slot of axis n against its status inputs
  task automatic check_slot(input int n);
    rim_axis_stat_s s;
    logic [15:0]    e;
    s = axis_stat[n];
    e = {s.inside_zone_flag, 1'b0, s.ready, mode_8bit & s.alarm_flag,
         s.homed_flag, s.motion_flag, s.lost_step_flag, s.start_echo,
         s.alarm_flag, s.warning_flag, s.op_select_echo};
    if (mode_8bit) check("slot", tx_frame[8*(6+n)+:8], e[15:8]);
    else check("slot", tx_frame[8*(6+2*n)+:16], e);
  endtask : check_slot
  initial begin
    arst_n = 1'b0;
    mode_8bit = 1'b0;
    send_req = 1'b0;
    kick_req = 1'b0;
    frame_req = '0;
    cmd_err = 1'b1;
    cmd_res = 32'hA1B2C3D4;
    conn_st = 8'h96;
    frm_st = 16'h5AA5;
    miscompares = 0;
    samples_checked = 0;
    for (int i = 0; i < 16; i++) axis_stat[i] = {6'(i + 9), 8'(i * 37)};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    f = '0;
    f[15:0] = 16'h3C20;
    f[8*2+:16] = 16'hBEEF;
    f[8*22+:16] = 16'h5A3C;
    for (int n = 0; n < 8; n++) f[8*(6+2*n)+:16] = {2'h3, 6'(n*7), 2'h2, 6'(n+33)};
    xfer(f, 1'b1);
    check("head", {tx_frame[255:248], tx_frame[15:0]}, 24'h003C20);
    check("ctl", {frame_control, reg_address}, 24'hBEEF3C);
    check("stat", tx_frame[8*2+:32], 32'h00965AA5);
    check("radr", tx_frame[8*22+:16], 16'h5A3C);
    for (int n = 0; n < 8; n++) begin
      check_slot(n);
      check("cmd", axis_cmd[n], {6'(n + 33), rev6(6'(n * 7))});
    end
    check("runs", axis_action[1].run_pos | axis_action[1].run_neg, 0);
    check("stop", axis_action[3].run_neg, 1'b0);
    check("prio", {axis_action[7], axis_action[6]}, 12'hC28);
    check("run5", axis_action[5], 6'h28);
    @(posedge clk);
    mode_8bit <= 1'b1;
    for (int n = 0; n < 16; n++) f[8*(6+n)+:8] = {2'h1, 6'(n * 7)};
    xfer(f, 1'b1);
    for (int n = 0; n < 16; n++) begin
      check_slot(n);
      check("cmd8", axis_cmd[n][5:0], rev6(6'(n * 7)));
    end
    f[7:0] = 8'h21;
    xfer(f, 1'b0);
    @(posedge clk);
    mode_8bit <= 1'b0;
    f[7:0] = 8'h20;
    f[8*24+:48] = {32'h11223344, 16'h2C17};
    kick_req <= 1'b1;
    xfer(f, 1'b1);
    check("go", {seen_start, cmd_code, cmd_data}, {1'b1, 14'h2C17, 32'h11223344});
    repeat (6) @(posedge clk);
    xfer(f, 1'b1);
    check("done", {seen_start, tx_frame[8*24+:48]}, {1'b0, 32'hA1B2C3D4, 16'hEC17});
    xfer(f, 1'b1);
    check("held", seen_start, 1'b0);
    @(posedge clk);
    kick_req <= 1'b0;
    cmd_err <= 1'b0;
    repeat (2) @(posedge clk);
    kick_req <= 1'b1;
    xfer(f, 1'b1);
    check("rearm", {seen_start, tx_frame[206]}, 2'b10);
    repeat (6) @(posedge clk);
    xfer(f, 1'b1);
    check("ok", tx_frame[8*25+:8], 8'h6C);
    summarize();
  end
endmodule : tb_rim_frame_mapper
`default_nettype wire
